//--- atawc_pkg.sv
package atawc_pkg;

    // ==========================================================
    // timing
    localparam int CLK_MHZ     = 100;
    localparam int T_BSY_NS    = 400;
    // longest time, so the count rounds down
    localparam int BSY_MAX_CYC = (T_BSY_NS * CLK_MHZ) / 1000;

    // ==========================================================
    // register offsets (16-bit words)
    localparam logic [3:0] OFS_DATA   = 4'h0;
    localparam logic [3:0] OFS_FEAT   = 4'h1;
    localparam logic [3:0] OFS_SCNT   = 4'h2;
    localparam logic [3:0] OFS_LBA_LO = 4'h3;
    localparam logic [3:0] OFS_LBA_MD = 4'h4;
    localparam logic [3:0] OFS_LBA_HI = 4'h5;
    localparam logic [3:0] OFS_DEVHD  = 4'h6;
    localparam logic [3:0] OFS_CMD_ST = 4'h7;
    localparam logic [3:0] OFS_ERROR  = 4'h8;
    localparam logic [3:0] OFS_MULT   = 4'h9;
    localparam logic [3:0] OFS_IDMULT = 4'ha;
    localparam logic [3:0] OFS_TAG    = 4'hb;

    // ==========================================================
    // field positions
    localparam int ST_BSY  = 7;
    localparam int ST_DRDY = 6;
    localparam int ST_DRQ  = 3;
    localparam int ST_ERR  = 0;
    localparam int ER_UNC  = 6;
    localparam int ER_ABRT = 2;
    localparam int DH_FUA  = 7;

    // ==========================================================
    // command codes
    localparam logic [7:0] CMD_WR_DMA_FUA = 8'h3d;
    localparam logic [7:0] CMD_WR_FPDMA   = 8'h61;
    localparam logic [7:0] CMD_WR_MULT    = 8'hc5;
    localparam logic [7:0] CMD_SET_MULT   = 8'hc6;

    // ==========================================================
    // counts, limits and zero-count values
    localparam logic [7:0]  SECT_LAST_WORD = 8'hff;
    localparam logic [7:0]  MAX_BLK        = 8'h01;
    localparam logic [16:0] CNT28_ZERO     = 17'h00100;
    localparam logic [16:0] CNT48_ZERO     = 17'h10000;

    typedef enum logic [2:0] {
        S_IDLE, S_DECODE, S_BLK_START, S_XFER,
        S_BLK_WAIT, S_FLUSH, S_FLUSH_WAIT, S_DONE
    } atawc_state_t;

    typedef struct packed {
        atawc_state_t state;
        logic [15:0]  feat;
        logic [15:0]  scnt;
        logic [15:0]  lba_lo;
        logic [15:0]  lba_md;
        logic [15:0]  lba_hi;
        logic [7:0]   devhd;
        logic [7:0]   cmd;
        logic [7:0]   mult;
        logic [4:0]   tag;
        logic         bsy;
        logic         drq;
        logic         err_st;
        logic         abrt;
        logic         unc;
        logic         intrq;
        logic         dmarq;
        logic         fua;
        logic         pio;
        logic         queued;
        logic         med_err;
        logic [16:0]  total;
        logic [16:0]  sent;
        logic [16:0]  acked;
        logic [16:0]  blk_left;
        logic [47:0]  base;
        logic [15:0]  rdata;
        logic         med_wstb;
        logic [15:0]  med_wdata;
        logic         med_sect;
        logic [47:0]  med_lba;
        logic         med_flush;
    } atawc_ctx_t;

    // all zero: idle, not busy, multiple mode off
    localparam atawc_ctx_t CTX_RST = '0;

endpackage

//--- atawc_sect_if.sv
interface atawc_sect_if;
    logic wstb;
    logic clear;
    logic sect_done;
    modport fill (input wstb, input clear, output sect_done);
    modport ctl  (output wstb, output clear, input sect_done);
endinterface

//--- atawc_sect_asm.sv
module atawc_sect_asm
    import atawc_pkg::*;
(
    input  wire logic  clk_i,
    input  wire logic  rst_i,
    atawc_sect_if.fill sif
);

    logic [7:0] cnt;
    logic [7:0] next_cnt;

    // ==========================================================
    // word counter, one sector per wrap
    always_comb begin
        next_cnt = cnt;
        if (sif.clear) begin
            next_cnt = 8'h00;
        end else if (sif.wstb) begin
            next_cnt = cnt + 8'h01;
        end
    end

    assign sif.sect_done = sif.wstb && !sif.clear && (cnt == SECT_LAST_WORD);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt <= 8'h00;
        end else begin
            cnt <= next_cnt;
        end
    end

endmodule // atawc_sect_asm

//--- atawc_blk_plan.sv
module atawc_blk_plan
    import atawc_pkg::*;
(
    input  wire logic [16:0] remaining_i,
    input  wire logic [7:0]  blk_size_i,
    output logic      [16:0] blk_len_o
);

    // ==========================================================
    // full block while enough remains, else the remainder
    always_comb begin
        if (remaining_i < {9'h000, blk_size_i}) begin
            blk_len_o = remaining_i;
        end else begin
            blk_len_o = {9'h000, blk_size_i};
        end
    end

endmodule // atawc_blk_plan

//--- atawc_top.sv
// Behaviour
// - fua dma ext write commits media before status
// - queued dma write moves host data in
// - queued write with fua commits before completion
// - queued write without fua may complete early
// - busy within 400 ns of multiple write
// - multiple write interrupts per block, not sector
// - data request qualifies only each block start
// - multiple write aborted when mode not set
// - sector count holds sectors, not blocks
// - full blocks then one partial remainder block
// - errors posted after the block finishes
// - command ends at the failing sector
// - no further blocks after an error
// - interrupt with each block data request
// - error leaves failing address and residual count
// - only block size one, shown by identify
// - 28-bit count zero means 256 sectors
// - 48-bit dma count 1 to 65536 sectors
module atawc_top
    import atawc_pkg::*;
(
    input  wire logic        CLK_I,
    input  wire logic        RST_I,
    input  wire logic [3:0]  ADDR_I,
    input  wire logic [15:0] WDATA_I,
    input  wire logic        WR_I,
    input  wire logic        RD_I,
    output logic      [15:0] RDATA_O,
    output logic             INTRQ_O,
    output logic             DMARQ_O,
    output logic             MED_WSTB_O,
    output logic      [15:0] MED_WDATA_O,
    output logic             MED_SECT_O,
    output logic      [47:0] MED_LBA_O,
    output logic             MED_FLUSH_O,
    input  wire logic        MED_DONE_I,
    input  wire logic        MED_ERR_I
);

    atawc_ctx_t  r;
    atawc_ctx_t  next_r;
    logic [15:0] status_w;
    logic [15:0] error_w;
    logic [47:0] lba48;
    logic [47:0] lba28;
    logic [47:0] done_addr;
    logic [16:0] residual;
    logic [16:0] remaining;
    logic [16:0] blk_len;
    logic        tf_open;
    logic        cmd_wr;
    logic        data_wr;

    atawc_sect_if sif ();

    // ==========================================================
    // helpers
    assign lba48 = {r.lba_hi[15:8], r.lba_md[15:8], r.lba_lo[15:8],
                    r.lba_hi[7:0], r.lba_md[7:0], r.lba_lo[7:0]};
    // host provides lba mode and bits 27-24 in the low nibble
    assign lba28 = {20'h00000, r.devhd[3:0], r.lba_hi[7:0],
                    r.lba_md[7:0], r.lba_lo[7:0]};
    assign done_addr = r.base + (r.med_err ? {31'h0, r.acked}
                                           : ({31'h0, r.total} - 48'h1));
    assign residual  = r.total - r.acked;
    assign remaining = r.total - r.sent;
    // taskfile frozen while busy or mid data phase
    assign tf_open = !r.bsy && !r.drq;
    assign cmd_wr  = WR_I && ADDR_I == OFS_CMD_ST && r.state == S_IDLE;
    assign data_wr = WR_I && ADDR_I == OFS_DATA && r.state == S_XFER;

    assign sif.wstb  = data_wr;
    assign sif.clear = r.state == S_DECODE;

    atawc_sect_asm u_sect (
        .clk_i (CLK_I),
        .rst_i (RST_I),
        .sif   (sif)
    );

    atawc_blk_plan u_plan (
        .remaining_i (remaining),
        .blk_size_i  (r.mult),
        .blk_len_o   (blk_len)
    );

    always_comb begin
        status_w          = 16'h0000;
        status_w[ST_BSY]  = r.bsy;
        status_w[ST_DRDY] = !r.bsy;
        status_w[ST_DRQ]  = r.drq;
        status_w[ST_ERR]  = r.err_st;
        error_w           = 16'h0000;
        error_w[ER_UNC]   = r.unc;
        error_w[ER_ABRT]  = r.abrt;
    end

    // ==========================================================
    // register port and command sequencer
    always_comb begin
        next_r           = r;
        next_r.med_wstb  = data_wr;
        next_r.med_wdata = WDATA_I;
        next_r.med_sect  = 1'b0;
        next_r.med_flush = 1'b0;
        next_r.rdata     = 16'h0000;

        if (RD_I) begin
            unique case (ADDR_I)
                OFS_FEAT:   next_r.rdata = r.feat;
                OFS_SCNT:   next_r.rdata = r.scnt;
                OFS_LBA_LO: next_r.rdata = r.lba_lo;
                OFS_LBA_MD: next_r.rdata = r.lba_md;
                OFS_LBA_HI: next_r.rdata = r.lba_hi;
                OFS_DEVHD:  next_r.rdata = {8'h00, r.devhd};
                OFS_CMD_ST: begin
                    next_r.rdata = status_w;
                    next_r.intrq = 1'b0;
                end
                OFS_ERROR:  next_r.rdata = error_w;
                OFS_MULT:   next_r.rdata = {8'h00, r.mult};
                OFS_IDMULT: next_r.rdata = {8'h00, MAX_BLK};
                OFS_TAG:    next_r.rdata = {11'h000, r.tag};
                default:    next_r.rdata = 16'h0000;
            endcase
        end

        if (WR_I && tf_open) begin
            unique case (ADDR_I)
                OFS_FEAT:   next_r.feat   = WDATA_I;
                OFS_SCNT:   next_r.scnt   = WDATA_I;
                OFS_LBA_LO: next_r.lba_lo = WDATA_I;
                OFS_LBA_MD: next_r.lba_md = WDATA_I;
                OFS_LBA_HI: next_r.lba_hi = WDATA_I;
                OFS_DEVHD:  next_r.devhd  = WDATA_I[7:0];
                default:    ;
            endcase
        end

        // media results come back in sector order
        if (MED_DONE_I && r.acked != r.sent && !r.med_err) begin
            if (MED_ERR_I) begin
                next_r.med_err = 1'b1;
            end else begin
                next_r.acked = r.acked + 17'h1;
            end
        end

        unique case (r.state)
            S_IDLE: begin
                if (cmd_wr) begin
                    next_r.cmd    = WDATA_I[7:0];
                    next_r.bsy    = 1'b1;
                    next_r.drq    = 1'b0;
                    next_r.intrq  = 1'b0;
                    next_r.abrt   = 1'b0;
                    next_r.unc    = 1'b0;
                    next_r.err_st = 1'b0;
                    next_r.state  = S_DECODE;
                end
            end
            S_DECODE: begin
                next_r.total   = 17'h0;
                next_r.sent    = 17'h0;
                next_r.acked   = 17'h0;
                next_r.med_err = 1'b0;
                next_r.fua     = 1'b0;
                next_r.pio     = 1'b0;
                next_r.queued  = 1'b0;
                next_r.state   = S_DONE;
                unique case (r.cmd)
                    CMD_SET_MULT: begin
                        if (r.scnt[7:0] <= MAX_BLK) begin
                            next_r.mult = r.scnt[7:0];
                        end else begin
                            next_r.abrt = 1'b1;
                        end
                    end
                    CMD_WR_MULT: begin
                        if (r.mult == 8'h00) begin
                            next_r.abrt = 1'b1;
                        end else begin
                            // count is sectors, zero means 256
                            next_r.total = (r.scnt[7:0] == 8'h00) ?
                                CNT28_ZERO : {9'h000, r.scnt[7:0]};
                            next_r.base  = lba28;
                            next_r.pio   = 1'b1;
                            next_r.state = S_BLK_START;
                        end
                    end
                    CMD_WR_DMA_FUA: begin
                        next_r.total = (r.scnt == 16'h0000) ?
                            CNT48_ZERO : {1'b0, r.scnt};
                        next_r.base  = lba48;
                        next_r.fua   = 1'b1;
                        next_r.dmarq = 1'b1;
                        next_r.state = S_XFER;
                    end
                    CMD_WR_FPDMA: begin
                        next_r.total  = (r.feat == 16'h0000) ?
                            CNT48_ZERO : {1'b0, r.feat};
                        next_r.base   = lba48;
                        next_r.fua    = r.devhd[DH_FUA];
                        next_r.queued = 1'b1;
                        next_r.tag    = r.scnt[7:3];
                        next_r.dmarq  = 1'b1;
                        next_r.state  = S_XFER;
                    end
                    default: next_r.abrt = 1'b1;
                endcase
            end
            S_BLK_START: begin
                // full blocks first, then the remainder
                next_r.blk_left = blk_len;
                next_r.drq      = 1'b1;
                next_r.bsy      = 1'b0;
                next_r.intrq    = 1'b1;
                next_r.state    = S_XFER;
            end
            S_XFER: begin
                if (sif.sect_done) begin
                    next_r.sent     = r.sent + 17'h1;
                    next_r.med_sect = 1'b1;
                    next_r.med_lba  = r.base + {31'h0, r.sent};
                end
                if (r.pio) begin
                    // no per-sector handshake inside a block
                    if (sif.sect_done) begin
                        next_r.blk_left = r.blk_left - 17'h1;
                        if (r.blk_left == 17'h1) begin
                            next_r.drq   = 1'b0;
                            next_r.bsy   = 1'b1;
                            next_r.state = S_BLK_WAIT;
                        end
                    end
                end else if (r.med_err ||
                    (sif.sect_done && r.sent + 17'h1 == r.total)) begin
                    next_r.dmarq = 1'b0;
                    next_r.state = S_BLK_WAIT;
                end
            end
            S_BLK_WAIT: begin
                if (r.med_err) begin
                    next_r.state = S_DONE;
                end else if (r.acked == r.sent || (r.queued && !r.fua)) begin
                    // without fua the queued write may finish early
                    if (r.pio && r.sent != r.total) begin
                        next_r.state = S_BLK_START;
                    end else if (r.fua) begin
                        next_r.state = S_FLUSH;
                    end else begin
                        next_r.state = S_DONE;
                    end
                end
            end
            S_FLUSH: begin
                next_r.med_flush = 1'b1;
                next_r.state     = S_FLUSH_WAIT;
            end
            S_FLUSH_WAIT: begin
                if (MED_DONE_I) begin
                    next_r.unc   = MED_ERR_I;
                    next_r.state = S_DONE;
                end
            end
            S_DONE: begin
                next_r.bsy    = 1'b0;
                next_r.drq    = 1'b0;
                next_r.dmarq  = 1'b0;
                next_r.intrq  = 1'b1;
                next_r.unc    = r.unc | r.med_err;
                next_r.err_st = r.abrt | r.unc | r.med_err;
                if (r.total != 17'h0) begin
                    // failing sector (last sector if none failed) and what is still owed
                    next_r.lba_lo = {done_addr[31:24], done_addr[7:0]};
                    next_r.lba_md = {done_addr[39:32], done_addr[15:8]};
                    next_r.lba_hi = {done_addr[47:40], done_addr[23:16]};
                    next_r.scnt   = r.med_err ? residual[15:0]
                                              : 16'h0000;
                    if (r.pio) begin
                        next_r.devhd[3:0] = done_addr[27:24];
                    end
                end
                next_r.state = S_IDLE;
            end
        endcase
    end

    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            r <= CTX_RST;
        end else begin
            r <= next_r;
        end
    end

    assign RDATA_O     = r.rdata;
    assign INTRQ_O     = r.intrq;
    assign DMARQ_O     = r.dmarq;
    assign MED_WSTB_O  = r.med_wstb;
    assign MED_WDATA_O = r.med_wdata;
    assign MED_SECT_O  = r.med_sect;
    assign MED_LBA_O   = r.med_lba;
    assign MED_FLUSH_O = r.med_flush;

    // ==========================================================
    // checks
    localparam int BSY_WIN = BSY_MAX_CYC;

    logic flushed;

    always_ff @(posedge CLK_I) begin
        if (RST_I || r.state == S_DECODE) begin
            flushed <= 1'b0;
        end else if (r.state == S_FLUSH_WAIT && MED_DONE_I) begin
            flushed <= 1'b1;
        end
    end

    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (RST_I);

    sequence s_cmd_in;
        WR_I && ADDR_I == OFS_CMD_ST && r.state == S_IDLE;
    endsequence

    sequence s_blk_open;
        r.state == S_BLK_START ##1 (r.drq && r.intrq && !r.bsy);
    endsequence

    a_busy_on_cmd: assert property (
        s_cmd_in |-> ##[1:BSY_WIN] r.bsy)
        else $error("busy not raised in time");
    a_block_irq: assert property (
        r.state == S_BLK_START |-> s_blk_open)
        else $error("block start without drq and interrupt");
    a_drq_at_block: assert property (
        $rose(r.drq) |-> $past(r.state) == S_BLK_START)
        else $error("drq raised outside block start");
    a_irq_per_block: assert property (
        $rose(r.intrq) |-> $past(r.state) inside {S_BLK_START, S_DONE})
        else $error("interrupt raised mid block");
    a_mult_abort: assert property (
        r.state == S_DECODE && r.cmd == CMD_WR_MULT && r.mult == 8'h00
        |=> r.state == S_DONE && r.abrt ##1 r.err_st)
        else $error("multiple write not aborted");
    a_partial_blk: assert property (
        r.state == S_BLK_START |=> r.blk_left == ($past(remaining) <
            {9'h000, r.mult} ? $past(remaining) : {9'h000, r.mult}))
        else $error("partial block length wrong");
    a_err_residual: assert property (
        r.state == S_DONE && r.med_err && r.total != 17'h0
        |=> r.scnt == $past(residual[15:0]))
        else $error("residual count wrong");
    a_no_blk_after: assert property (
        r.med_err |-> r.state != S_BLK_START)
        else $error("block started after error");
    a_dma_err_stop: assert property (
        r.med_err && !r.pio && r.state == S_XFER |=> !r.dmarq)
        else $error("dma request kept after error");
    a_fua_commit: assert property (
        r.state == S_DONE && r.fua && !r.med_err && r.total != 17'h0
        |-> flushed)
        else $error("fua completion before media commit");
    a_count_256: assert property (
        r.state == S_DECODE && r.cmd == CMD_WR_MULT && r.mult != 8'h00
        && r.scnt[7:0] == 8'h00 |=> r.total == CNT28_ZERO)
        else $error("zero count not taken as 256");

endmodule // atawc_top

//--- atawc_media_model.sv
module atawc_media_model (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        sect_i,
    input  wire logic        flush_i,
    input  wire logic [47:0] lba_i,
    input  wire logic [7:0]  dly_i,
    input  wire logic        fail_en_i,
    input  wire logic [47:0] fail_lba_i,
    output logic             done_o,
    output logic             err_o
);
    timeunit 1ns;
    timeprecision 1ps;

    // ====================
    // in-order results, one per sector or flush
    logic q[$];
    int   cnt = 0;
    logic e;

    always @(posedge clk_i) begin
        // idle line toggles so a stale result never looks valid
        e = ~err_o;
        done_o <= 1'b0;
        if (rst_i) begin
            q.delete();
            cnt = 0;
            e = 1'b0;
        end else begin
            if (sect_i)
                q.push_back(fail_en_i && lba_i == fail_lba_i);
            if (flush_i)
                q.push_back(1'b0);
            if (q.size() > 0) begin
                if (cnt >= int'(dly_i)) begin
                    done_o <= 1'b1;
                    e = q.pop_front();
                    cnt = 0;
                end else begin
                    cnt++;
                end
            end
        end
        err_o <= e;
    end
endmodule // atawc_media_model

//--- testbench.sv
module testbench
    import atawc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic        clk;
    logic        rst;
    logic [3:0]  addr;
    logic [15:0] wdata;
    logic        wr_stb;
    logic        rd_stb;
    logic [15:0] rdata;
    logic        intrq;
    logic        dmarq;
    logic        med_wstb;
    logic [15:0] med_wdata;
    logic        med_sect;
    logic [47:0] med_lba;
    logic        med_flush;
    logic        med_done;
    logic        med_err;
    logic [7:0]  dly = 8'h02;
    logic        fail_en = 1'b0;
    logic [47:0] fail_lba = '0;
    logic [15:0] st;
    logic [47:0] last_lba;
    logic        irq_q = 1'b0;
    int err_count = 0;
    int n_checks = 0;
    int cyc = 0;
    int n_irq = 0;
    int n_sect = 0;
    int n_flush = 0;
    int n_done = 0;
    int n_words = 0;

    atawc_top u_dut (
        .CLK_I(clk), .RST_I(rst), .ADDR_I(addr), .WDATA_I(wdata),
        .WR_I(wr_stb), .RD_I(rd_stb), .RDATA_O(rdata), .INTRQ_O(intrq),
        .DMARQ_O(dmarq), .MED_WSTB_O(med_wstb), .MED_WDATA_O(med_wdata),
        .MED_SECT_O(med_sect), .MED_LBA_O(med_lba),
        .MED_FLUSH_O(med_flush), .MED_DONE_I(med_done),
        .MED_ERR_I(med_err)
    );

    atawc_media_model u_med (
        .clk_i(clk), .rst_i(rst), .sect_i(med_sect), .flush_i(med_flush),
        .lba_i(med_lba), .dly_i(dly), .fail_en_i(fail_en),
        .fail_lba_i(fail_lba), .done_o(med_done), .err_o(med_err)
    );

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // ====================
    // event counters and hang guard
    always @(posedge clk) begin
        cyc++;
        irq_q <= intrq;
        if (intrq === 1'b1 && irq_q === 1'b0)
            n_irq++;
        if (med_sect === 1'b1) begin
            n_sect++;
            last_lba = med_lba;
        end
        if (med_flush === 1'b1)
            n_flush++;
        if (med_done === 1'b1)
            n_done++;
        if (med_wstb === 1'b1)
            n_words++;
        if (cyc >= 40000) begin
            err_count++;
            test_done();
        end
    end

    // ====================
    // bus tasks
    task automatic reg_wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk);
        addr   <= a;
        wdata  <= d;
        wr_stb <= 1'b1;
        @(posedge clk);
        wr_stb <= 1'b0;
    endtask

    task automatic reg_rd(input logic [3:0] a, output logic [15:0] d);
        @(posedge clk);
        addr   <= a;
        rd_stb <= 1'b1;
        @(posedge clk);
        rd_stb <= 1'b0;
        #1 d = rdata;
    endtask

    task automatic chk(input string nm, input logic [15:0] e,
                       input logic [15:0] g);
        n_checks++;
        if (g !== e) begin
            err_count++;
            $display("[ERR] %s exp %h got %h", nm, e, g);
        end
    endtask

    // counters cleared off the edge, so no race with the monitor
    task automatic clr();
        @(negedge clk);
        n_irq = 0;
        n_sect = 0;
        n_flush = 0;
        n_done = 0;
        n_words = 0;
    endtask

    task automatic wait_idle();
        for (int i = 0; i < 300; i++) begin
            reg_rd(OFS_CMD_ST, st);
            if (st[ST_BSY] === 1'b0)
                break;
        end
        chk("bsy", 16'h0000, {15'h0, st[ST_BSY]});
    endtask

    task automatic send_sect(input int n);
        for (int s = 0; s < n; s++)
            for (int w = 0; w < 256; w++)
                reg_wr(OFS_DATA, 16'(s * 256 + w));
    endtask

    // fixed lba: lo 0x34, mid 0x12, high 0
    task automatic issue(input logic [15:0] sc, input logic [15:0] ft,
                         input logic [7:0] dh, input logic [7:0] c);
        reg_wr(OFS_FEAT, ft);
        reg_wr(OFS_SCNT, sc);
        reg_wr(OFS_LBA_LO, 16'h0034);
        reg_wr(OFS_LBA_MD, 16'h0012);
        reg_wr(OFS_LBA_HI, 16'h0000);
        reg_wr(OFS_DEVHD, {8'h00, dh});
        reg_wr(OFS_CMD_ST, {8'h00, c});
    endtask

    task automatic run_mult();
        for (int k = 0; k < 4; k++) begin
            wait_idle();
            if (st[ST_DRQ] !== 1'b1)
                break;
            send_sect(1);
        end
    endtask

    task automatic dma_send(input int n);
        for (int i = 0; i < 50 && dmarq !== 1'b1; i++)
            @(negedge clk);
        chk("dmarq", 16'h0001, {15'h0, dmarq});
        send_sect(n);
    endtask

    task automatic test_done();
        $display("checks %0d errors %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // ====================
    // scenarios
    initial begin
        rst = 1'b1;
        addr = '0;
        wdata = '0;
        wr_stb = 1'b0;
        rd_stb = 1'b0;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        reg_rd(OFS_CMD_ST, st);
        chk("st rst", 16'h0040, st);
        reg_rd(OFS_IDMULT, st);
        chk("idmult", 16'h0001, st);
        reg_rd(4'hf, st);
        chk("unmapped", 16'h0000, st);
        clr();
        issue(16'h0001, 16'h0000, 8'h55, CMD_WR_MULT);
        wait_idle();
        chk("ab st", 16'h0041, st);
        reg_rd(OFS_ERROR, st);
        chk("ab er", 16'h0004, st);
        chk("ab irq", 16'd1, 16'(n_irq));
        chk("ab sect", 16'd0, 16'(n_sect));
        issue(16'h0002, 16'h0000, 8'h50, CMD_SET_MULT);
        wait_idle();
        reg_rd(OFS_MULT, st);
        chk("mult2", 16'h0000, st);
        issue(16'h0001, 16'h0000, 8'h50, CMD_SET_MULT);
        wait_idle();
        reg_rd(OFS_MULT, st);
        chk("mult1", 16'h0001, st);
        // three sectors, block of one, lba 0x5001234
        clr();
        issue(16'h0003, 16'h0000, 8'h55, CMD_WR_MULT);
        reg_rd(OFS_CMD_ST, st);
        chk("m busy", 16'h0001, {15'h0, st[ST_BSY] | st[ST_DRQ]});
        run_mult();
        chk("m st", 16'h0040, st);
        chk("m sect", 16'd3, 16'(n_sect));
        chk("m words", 16'd768, 16'(n_words));
        chk("m irq", 16'd4, 16'(n_irq));
        chk("m lbal", 16'h1236, last_lba[15:0]);
        chk("m lbah", 16'h0500, last_lba[31:16]);
        reg_rd(OFS_SCNT, st);
        chk("m scnt", 16'h0000, st);
        // media fails the second sector
        clr();
        fail_lba = 48'h5001235;
        fail_en = 1'b1;
        issue(16'h0003, 16'h0000, 8'h55, CMD_WR_MULT);
        run_mult();
        chk("e st", 16'h0041, st);
        chk("e words", 16'd512, 16'(n_words));
        chk("e sect", 16'd2, 16'(n_sect));
        chk("e irq", 16'd3, 16'(n_irq));
        reg_rd(OFS_ERROR, st);
        chk("e er", 16'h0040, st);
        reg_rd(OFS_SCNT, st);
        chk("e scnt", 16'h0002, st);
        reg_rd(OFS_LBA_LO, st);
        chk("e lba", 16'h0535, st);
        // slow media shows whether status waits for the flush
        clr();
        fail_en = 1'b0;
        dly = 8'd20;
        issue(16'h0002, 16'h0000, 8'h40, CMD_WR_DMA_FUA);
        dma_send(2);
        wait_idle();
        chk("f st", 16'h0040, st);
        chk("f flush", 16'd1, 16'(n_flush));
        chk("f done", 16'd3, 16'(n_done));
        chk("f words", 16'd512, 16'(n_words));
        clr();
        issue(16'h0028, 16'h0001, 8'hc0, CMD_WR_FPDMA);
        dma_send(1);
        wait_idle();
        chk("q1 flush", 16'd1, 16'(n_flush));
        chk("q1 done", 16'd2, 16'(n_done));
        chk("q1 words", 16'd256, 16'(n_words));
        reg_rd(OFS_TAG, st);
        chk("q1 tag", 16'h0005, st);
        clr();
        dly = 8'd100;
        issue(16'h0010, 16'h0001, 8'h40, CMD_WR_FPDMA);
        dma_send(1);
        wait_idle();
        chk("q0 done", 16'd0, 16'(n_done));
        chk("q0 flush", 16'd0, 16'(n_flush));
        repeat (120) @(posedge clk);
        reg_rd(OFS_CMD_ST, st);
        chk("q0 late", 16'h0040, st);
        // media fails the second dma sector: request drops, residual kept
        clr();
        dly = 8'd2;
        fail_lba = 48'h1235;
        fail_en = 1'b1;
        issue(16'h0003, 16'h0000, 8'h40, CMD_WR_DMA_FUA);
        dma_send(3);
        wait_idle();
        chk("d st", 16'h0041, st);
        chk("d sect", 16'd2, 16'(n_sect));
        reg_rd(OFS_SCNT, st);
        chk("d scnt", 16'h0002, st);
        test_done();
    end
endmodule // testbench
